//--- pkg/instr_timing_map.svh
`ifndef INSTR_TIMING_MAP_SVH
`define INSTR_TIMING_MAP_SVH
// instruction lengths in program bytes
`define LEN_ONE          3'h1
`define LEN_TWO          3'h2
`define LEN_THREE        3'h3
// execution times in clock cycles
`define CYC_ONE          4'h1
`define CYC_TWO          4'h2
`define CYC_THREE        4'h3
`define CYC_MUL          4'h4
`define CYC_DIV          4'h8
// xdata steering control bits
`define XSEL_FLASH_BIT   0
`define XSEL_WRITE_BIT   1
`define XDATA_ADDR_W     16
`endif

//--- pkg/instr_timing_pkg.sv
package instr_timing_pkg;

  typedef enum logic [3:0] {
    SPACE_NONE  = 4'h1,
    SPACE_XRAM  = 4'h2,
    SPACE_FLASH = 4'h4,
    SPACE_EXT   = 4'h8
  } xspace_type;

  typedef struct packed {
    logic [2:0] length;
    logic [3:0] cycles;
    logic       is_branch;
    logic       is_xmove;
    logic       known;
  } decode_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
    xspace_type  space;
  } xreq_type;

endpackage

//--- src/instr_length_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "instr_timing_map.svh"
// pure decode of opcode to length and cycle count
module instr_length_decoder
(
  input  wire logic [7:0]                  opcode,
  output instr_timing_pkg::decode_type     info
);

  wire [3:0] hi       = opcode[7:4];
  wire [3:0] lo       = opcode[3:0];
  wire       is_rn    = opcode[3];
  wire       is_ri    = (lo == 4'h6) || (lo == 4'h7);
  wire       is_dir   = (lo == 4'h5);
  wire       is_imm   = (lo == 4'h4);
  wire       alu_grp  = (hi == 4'h2) || (hi == 4'h3) || (hi == 4'h9);
  wire       log_grp  = (hi == 4'h4) || (hi == 4'h5) || (hi == 4'h6);
  wire       incdec   = (hi == 4'h0) || (hi == 4'h1);
  wire       xmove    = (opcode == 8'hE0) || (opcode == 8'hF0) || ((hi >= 4'hE) && (lo >= 4'h2)
                        && (lo <= 4'h3));
  wire       cond_br  = (opcode == 8'h40) || (opcode == 8'h50) || (opcode == 8'h60)
                        || (opcode == 8'h70);

  function automatic instr_timing_pkg::decode_type mk(input logic [2:0] l, input logic [3:0] c);
    instr_timing_pkg::decode_type r;
    r = '0;
    r.length = l;
    r.cycles = c;
    r.known  = 1'b1;
    return r;
  endfunction

  always_comb
  begin
    info = mk(`LEN_ONE, `CYC_ONE);
    info.known = 1'b0;
    if ((alu_grp || log_grp) && is_rn)
      info = mk(`LEN_ONE, `CYC_ONE);
    else if ((alu_grp || log_grp) && (is_dir || is_imm))
      info = mk(`LEN_TWO, `CYC_TWO);
    else if ((alu_grp || log_grp) && is_ri)
      info = mk(`LEN_ONE, `CYC_TWO);
    else if (log_grp && (lo == 4'h2))
      info = mk(`LEN_TWO, `CYC_TWO);
    else if (log_grp && (lo == 4'h3))
      info = mk(`LEN_THREE, `CYC_THREE);
    else if (incdec && (is_rn || lo == 4'h4))
      info = mk(`LEN_ONE, `CYC_ONE);
    else if (incdec && is_dir)
      info = mk(`LEN_TWO, `CYC_TWO);
    else if (incdec && is_ri)
      info = mk(`LEN_ONE, `CYC_TWO);
    else if ((opcode == 8'hA3) || (opcode == 8'hD4) || (opcode == 8'hE4) || (opcode == 8'hF4)
             || (opcode == 8'h23) || (opcode == 8'h33))
      info = mk(`LEN_ONE, `CYC_ONE);
    else if (opcode == 8'hA4)
      info = mk(`LEN_ONE, `CYC_MUL);
    else if (opcode == 8'h84)
      info = mk(`LEN_ONE, `CYC_DIV);
    else if (cond_br)
    begin
      info = mk(`LEN_TWO, `CYC_THREE);
      info.is_branch = 1'b1;
    end
    else if (xmove)
    begin
      info = mk(`LEN_ONE, `CYC_THREE);
      info.is_xmove = 1'b1;
    end
  end

endmodule // instr_length_decoder
`default_nettype wire

//--- src/xdata_steer.sv
`timescale 1ns/1ps
`default_nettype none
`include "instr_timing_map.svh"
// picks the space an external-data move reaches
module xdata_steer
#(
  parameter bit HAS_XRAM = 1'b1
)
(
  input  wire logic [1:0]               program_store_control,
  output instr_timing_pkg::xspace_type  space
);

  wire flash_sel = program_store_control[`XSEL_FLASH_BIT];

  assign space = flash_sel ? instr_timing_pkg::SPACE_FLASH
               : (HAS_XRAM ? instr_timing_pkg::SPACE_XRAM
                           : instr_timing_pkg::SPACE_EXT);

endmodule // xdata_steer
`default_nettype wire

//--- src/cpu_instruction_timing.sv
`timescale 1ns/1ps
`default_nettype none
`include "instr_timing_map.svh"
// Operation
// - every instruction time is counted in plain system clocks, no machine cycles.
// - most instructions finish in as many clocks as they have program bytes.
// - a conditional branch not taken finishes one clock sooner than when taken.
// - the external-data move reaches program flash when the control bits select it.
// - with on-chip xram, the move reaches that ram when external data space is selected.
// - add, add-with-carry, subtract-with-borrow from a working register take 1 byte, 1 clock.
// - those with direct or immediate source take 2 bytes and 2 clocks.
// - those with register-indirect source take 1 byte and 2 clocks.
// - and, or, xor of a working register into the accumulator take 1 byte, 1 clock.
// - and, or, xor direct/immediate into acc or acc into direct take 2 bytes, 2 clocks.
// - and, or, xor with register-indirect source take 1 byte and 2 clocks.
// - and, or, xor immediate into a direct byte take 3 bytes and 3 clocks.
// - clear, complement, rotate left, rotate left through carry take 1 clock.
module cpu_instruction_timing
#(
  parameter bit HAS_XRAM = 1'b1
)
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  input  wire logic                   issue_valid,
  input  wire logic [7:0]             issue_opcode,
  input  wire logic                   branch_taken,
  input  wire logic [1:0]             program_store_control,
  input  wire logic [15:0]            xmove_addr,
  input  wire logic [7:0]             xmove_wdata,
  output logic                        issue_ready,
  output logic                        retire,
  output logic [2:0]                  retire_length,
  output logic [3:0]                  retire_cycles,
  output instr_timing_pkg::xreq_type  xreq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } state_type;

  state_type                    state_q, state_d;
  logic [3:0]                   left_q, left_d;
  logic [3:0]                   total_q;
  logic [2:0]                   len_q;
  instr_timing_pkg::decode_type info;
  instr_timing_pkg::xspace_type space;

  instr_length_decoder u_dec
  (
    .opcode (issue_opcode),
    .info   (info)
  );

  xdata_steer #(.HAS_XRAM(HAS_XRAM)) u_steer
  (
    .program_store_control (program_store_control),
    .space                 (space)
  );

  // ----------------------------------------------------------------
  // cycle budget
  // ----------------------------------------------------------------
  wire       take     = issue_valid && issue_ready;
  wire [3:0] budget   = (info.is_branch && !branch_taken)
                        ? 4'(info.cycles - `CYC_ONE) : info.cycles;
  wire       last     = (state_q == ST_BUSY) && (left_q == `CYC_ONE);
  wire       one_shot = take && (budget == `CYC_ONE);

  always_comb
  begin
    state_d = state_q;
    left_d  = left_q;
    case (state_q)
      ST_IDLE:
        if (take && !one_shot)
        begin
          state_d = ST_BUSY;
          left_d  = 4'(budget - `CYC_ONE);
        end
      ST_BUSY:
        if (left_q == `CYC_ONE)
          state_d = ST_IDLE;
        else
          left_d = 4'(left_q - `CYC_ONE);
      default:
        state_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_q       <= ST_IDLE;
      left_q        <= '0;
      total_q       <= '0;
      len_q         <= '0;
      issue_ready   <= 1'b1;
      retire        <= 1'b0;
      retire_length <= '0;
      retire_cycles <= '0;
      xreq          <= '{valid: 1'b0, write: 1'b0, addr: '0, wdata: '0,
                         space: instr_timing_pkg::SPACE_NONE};
    end
    else if (clk_en)
    begin
      state_q     <= state_d;
      left_q      <= left_d;
      issue_ready <= (state_d == ST_IDLE);
      retire      <= one_shot || last;
      if (take)
      begin
        total_q <= budget;
        len_q   <= info.length;
      end
      if (one_shot)
      begin
        retire_length <= info.length;
        retire_cycles <= budget;
      end
      else if (last)
      begin
        retire_length <= len_q;
        retire_cycles <= total_q;
      end
      xreq.valid <= take && info.is_xmove;
      if (take && info.is_xmove)
      begin
        xreq.write <= issue_opcode[4];
        xreq.addr  <= xmove_addr;
        xreq.wdata <= xmove_wdata;
        xreq.space <= space;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_retire_single: assert property (clk_en && take && budget == 4'h1 |=> retire)
    else $error("single-cycle instruction did not retire next edge");
  a_mul_four: assert property (clk_en && take && issue_opcode == 8'hA4 |=> !issue_ready[*3])
    else $error("multiply did not hold for four clocks");
  a_div_eight: assert property (clk_en && take && issue_opcode == 8'h84
                                |=> !issue_ready[*7])
    else $error("divide did not hold for eight clocks");
  a_branch_short: assert property (take && info.is_branch && !branch_taken
                                   |-> budget == 4'h2 && info.cycles == 4'h3)
    else $error("untaken branch not one clock shorter");
  a_flash_steer: assert property (take && info.is_xmove && program_store_control[0] && clk_en
                                  |=> xreq.space == instr_timing_pkg::SPACE_FLASH)
    else $error("move not steered to flash");
  a_xram_steer: assert property (take && info.is_xmove && !program_store_control[0] && clk_en
                                 && HAS_XRAM |=> xreq.space == instr_timing_pkg::SPACE_XRAM)
    else $error("move not steered to xram");
  a_rn_length: assert property (take && info.known && issue_opcode[3] && issue_opcode[7:4] == 4'h2
                                |-> info.length == 3'h1 && info.cycles == 4'h1)
    else $error("register add not one byte one clock");
  a_dir_imm3: assert property (take && issue_opcode == 8'h43
                               |-> info.length == 3'h3 && info.cycles == 4'h3)
    else $error("immediate to direct logic op not three");
  a_ri_two: assert property (take && issue_opcode == 8'h56
                             |-> info.length == 3'h1 && info.cycles == 4'h2)
    else $error("indirect logic op not one byte two clocks");
  a_len_match: assert property (clk_en && take && issue_opcode == 8'h25
                                |=> !issue_ready ##1 (clk_en ? issue_ready : 1'b1))
    else $error("direct add not two clocks");

  c_single: cover property (take && budget == 4'h1);
  c_div: cover property (take && issue_opcode == 8'h84);
  c_branch_nt: cover property (take && info.is_branch && !branch_taken);
  c_flash: cover property (xreq.valid && xreq.space == instr_timing_pkg::SPACE_FLASH);

endmodule // cpu_instruction_timing
`default_nettype wire

//--- dv/xmem_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side memories reached by the external-data move
module xmem_model
(
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire instr_timing_pkg::xreq_type  xreq
);
  logic [7:0] flash_mem [0:255];
  logic [7:0] xram_mem  [0:255];
  int         flash_hits;
  int         xram_hits;

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      flash_hits = 0;
      xram_hits  = 0;
    end
    else if (xreq.valid === 1'b1)
    begin
      if (xreq.space === instr_timing_pkg::SPACE_FLASH)
      begin
        flash_hits++;
        if (xreq.write)
          flash_mem[xreq.addr[7:0]] = xreq.wdata;
      end
      if (xreq.space === instr_timing_pkg::SPACE_XRAM)
      begin
        xram_hits++;
        if (xreq.write)
          xram_mem[xreq.addr[7:0]] = xreq.wdata;
      end
    end
  end
endmodule // xmem_model
`default_nettype wire

//--- dv/cpu_instruction_timing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_instruction_timing_tb;
  logic                       clk_sys = 1'b0;
  logic                       rst_n = 1'b0;
  logic                       clk_en = 1'b1;
  logic                       issue_valid = 1'b0;
  logic [7:0]                 issue_opcode = 8'h00;
  logic                       branch_taken = 1'b0;
  logic [1:0]                 program_store_control = 2'h0;
  logic [15:0]                xmove_addr = 16'h0042;
  logic [7:0]                 xmove_wdata = 8'hA5;
  logic                       issue_ready;
  logic                       retire;
  logic [2:0]                 retire_length;
  logic [3:0]                 retire_cycles;
  instr_timing_pkg::xreq_type xreq;
  int                         miscompares = 0;
  int                         checked = 0;
  int                         n;
  // row: opcode, taken, control, length, cycles
  logic [23:0] rows [36] = '{
    24'h280011, 24'h380011, 24'h980011, 24'h250022,
    24'h340022, 24'h960012, 24'h260012, 24'h580011,
    24'h480011, 24'h680011, 24'h550022, 24'h440022,
    24'h620022, 24'h560012, 24'h530033, 24'h430033,
    24'h630033, 24'hE40011, 24'hF40011, 24'h230011,
    24'h330011, 24'h040011, 24'h180011, 24'hA30011,
    24'hD40011, 24'h150022, 24'h060012, 24'hA40014,
    24'h840018, 24'h401023, 24'h400022, 24'h701023,
    24'h700022, 24'hE00113, 24'hF00013, 24'h000011};

  cpu_instruction_timing uut
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .issue_valid(issue_valid),
    .issue_opcode(issue_opcode), .branch_taken(branch_taken),
    .program_store_control(program_store_control), .xmove_addr(xmove_addr),
    .xmove_wdata(xmove_wdata), .issue_ready(issue_ready), .retire(retire),
    .retire_length(retire_length), .retire_cycles(retire_cycles), .xreq(xreq)
  );

  xmem_model mem (.clk_sys(clk_sys), .rst_n(rst_n), .xreq(xreq));

  always #10 clk_sys = ~clk_sys;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // counts clk_sys edges until retire, whatever clk_en is, bounded at 20
  task automatic wait_retire(output int cnt);
    cnt = 0;
    while (cnt < 20)
    begin
      @(posedge clk_sys);
      cnt++;
      #1;
      if (cnt == 1)
        chk("mul xreq valid", 16'h0, {15'h0, xreq.valid});
      if (retire === 1'b1)
        break;
    end
    if (retire !== 1'b1)
    begin
      chk("retire timeout", 16'h1, 16'h0);
      results();
    end
  endtask

  task automatic run(input logic [23:0] r);
    @(posedge clk_sys);
    issue_opcode          <= r[23:16];
    branch_taken          <= r[12];
    program_store_control <= r[9:8];
    issue_valid           <= 1'b1;
    // take edge; outputs launched here are looked at 1 ns later
    @(posedge clk_sys);
    issue_valid           <= 1'b0;
    #1;
    n = 1;
    if (r[23:16] inside {8'hE0, 8'hF0})
    begin
      chk("xreq valid", 16'h1, {15'h0, xreq.valid});
      chk("xreq space", r[8] ? 16'h4 : 16'h2, {12'h0, xreq.space});
      chk("xreq write", {15'h0, r[20]}, {15'h0, xreq.write});
      chk("xreq addr", 16'h0042, xreq.addr);
    end
    while (retire !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (retire !== 1'b1)
    begin
      chk("retire timeout", 16'h1, 16'h0);
      results();
    end
    chk("retire edges", {12'h0, r[3:0]}, n[15:0]);
    chk("retire_length", {13'h0, r[6:4]}, {13'h0, retire_length});
    chk("retire_cycles", {12'h0, r[3:0]}, {12'h0, retire_cycles});
  endtask

  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk("reset issue_ready", 16'h1, {15'h0, issue_ready});
    chk("reset retire", 16'h0, {15'h0, retire});
    chk("reset space", 16'h1, {12'h0, xreq.space});
    foreach (rows[i])
      run(rows[i]);
    chk("xram written", 16'h00A5, {8'h0, mem.xram_mem[8'h42]});
    chk("flash hits", 16'h1, mem.flash_hits[15:0]);
    // back to back one-clock operations
    @(posedge clk_sys);
    issue_opcode <= 8'hE4;
    issue_valid  <= 1'b1;
    @(posedge clk_sys);
    issue_opcode <= 8'hF4;
    #1;
    chk("first retire", 16'h1, {15'h0, retire});
    @(posedge clk_sys);
    issue_valid  <= 1'b0;
    #1;
    chk("second retire", 16'h1, {15'h0, retire});
    chk("second retire_cycles", 16'h1, {12'h0, retire_cycles});
    // freeze during multiply, with an offer held while busy
    @(posedge clk_sys);
    issue_opcode <= 8'hA4;
    issue_valid  <= 1'b1;
    @(posedge clk_sys);
    clk_en       <= 1'b0;
    issue_opcode <= 8'hE4;
    repeat (3) @(posedge clk_sys);
    clk_en       <= 1'b1;
    wait_retire(n);
    issue_valid  <= 1'b0;
    // take edge plus the enabled edges after the thaw
    chk("frozen mul edges", 16'h4, 16'(n + 1));
    chk("frozen mul cycles", 16'h4, {12'h0, retire_cycles});
    @(posedge clk_sys);
    #1;
    chk("busy offer refused", 16'h0, {15'h0, retire});
    // reset in the middle of a divide
    run(24'h000011);
    @(posedge clk_sys);
    issue_opcode <= 8'h84;
    issue_valid  <= 1'b1;
    @(posedge clk_sys);
    issue_valid  <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk("abort ready", 16'h1, {15'h0, issue_ready});
    n = 0;
    repeat (10)
    begin
      @(posedge clk_sys);
      #1;
      if (retire === 1'b1)
        n++;
    end
    chk("no retire after abort", 16'h0, n[15:0]);
    run(24'h401023);
    results();
  end
endmodule // cpu_instruction_timing_tb
`default_nettype wire
